// file: aehl_pkg.sv
// Purpose: constants for the error header log and secondary status bank
// Assumes: 32-bit avalon-mm word addressing by byte address
// Notes: offsets are byte addresses
package aehl_pkg;
  localparam logic [11:0] HL_WORD0_OFS = 12'h11c;
  localparam logic [11:0] HL_WORD1_OFS = 12'h120;
  localparam logic [11:0] HL_WORD2_OFS = 12'h124;
  localparam logic [11:0] HL_WORD3_OFS = 12'h128;
  localparam logic [11:0] SEC_STAT_OFS = 12'h12c;
  localparam logic [11:0] SEC_PTR_OFS = 12'h138;
  // status bit positions
  localparam int BIT_IB_FAULT = 13;
  localparam int BIT_SERR = 12;
  localparam int BIT_PERR = 11;
  localparam int BIT_DISCARD = 10;
  localparam int BIT_ADDR = 9;
  localparam int BIT_ATTR = 8;
  localparam int BIT_DATA = 7;
  localparam int BIT_RMA = 3;
  localparam int BIT_RTA = 2;
  // bits that hardware can ever set: 12,11,10,9,8,7,3,2
  localparam logic [13:0] STAT_LIVE_MASK = 14'h1f8c;
  // bits whose error carries a header log: 11,9,8,7,3,2
  localparam logic [13:0] STAT_HDR_MASK = 14'h0b8c;
  localparam logic [31:0] HL_RESET = 32'h00000000;
  localparam logic [13:0] STAT_RESET = 14'h0000;
  localparam logic [4:0] PTR_RESET = 5'h00;
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
endpackage : aehl_pkg

// file: aehl_first_bit.sv
// Purpose: finds lowest set bit index of an error event vector
// Assumes: purely combinational
// Notes: used for the first error pointer
`timescale 1ns/1ps
`default_nettype none
module aehl_first_bit #(
  parameter int WIDTH = 14
) (
  input wire logic [WIDTH-1:0] vec_i, // event bits
  output logic any_o, // some bit set
  output logic [4:0] idx_o // lowest set position
);
  initial begin
    if (WIDTH > 32) $error("aehl_first_bit: WIDTH above 32");
  end
  // scan from the top so the lowest set bit wins
  always_comb begin
    any_o = 1'b0;
    idx_o = 5'h00;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (vec_i[i]) begin
        any_o = 1'b1;
        idx_o = i[4:0];
      end
    end
  end
endmodule : aehl_first_bit
`default_nettype wire

// file: aehl_bank.sv
// Purpose: sticky header log and secondary uncorrectable status registers
// Assumes: avalon-mm slave, synchronous resets, event inputs are one-cycle pulses
// Notes: sticky state cleared only by power-on reset; reset_i clears bus state
//
// Overview of operation
// R1: register at 0x11c reads header bits 127 to 96, resets to zero.
// R2: register at 0x120 reads header bits 95 to 64, resets to zero.
// R3: register at 0x124 reads header bits 63 to 32, resets to zero.
// R4: register at 0x128 reads header bits 31 to 0, resets to zero.
// R5: the whole packet header of the logged error fills all four words.
// R6: status bit 13 internal bridge fault always reads zero.
// R7: bit 12 set on system error seen, no header captured.
// R8: bit 10 set on discard timer expiry, no header captured.
// R9: bit 9 set on address fault, write one clears.
// R10: bit 8 set on attribute fault, write one clears.
// R11: bit 7 set on data fault, write one clears.
// R12: split completion bits 6, 5, 1, 0 never set, read zero.
// R13: bits 11, 3, 2 record parity error and received aborts, sticky, w1c.
// R14: pointer at 0x138 bits 4:0 gives position of first recorded error.
// R15: write one clears, zero keeps; reserved bits read zero, ignore writes.
// R16: sticky bits survive every reset except power-on reset.
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module aehl_bank
  import aehl_pkg::*;
(
  input wire logic mclk_i, // 10 mhz core clock
  input wire logic reset_i, // non-sticky reset, active high
  input wire logic por_i, // power-on reset, active high
  // avalon-mm slave
  input wire logic [11:0] address_i, // byte address
  input wire logic read_i, // read request
  input wire logic write_i, // write request
  input wire logic [31:0] writedata_i, // write data
  input wire logic [3:0] byteenable_i, // byte lanes
  output logic [31:0] readdata_o, // read data
  output logic waitrequest_o, // stall
  // error events from the bridge
  input wire logic system_error_seen_i, // serr seen
  input wire logic parity_error_seen_i, // perr seen
  input wire logic discard_timer_expired_i, // delayed txn discarded
  input wire logic address_fault_i, // address error
  input wire logic attribute_fault_i, // attribute error
  input wire logic data_fault_i, // data error
  input wire logic received_master_abort_i, // master abort
  input wire logic received_target_abort_i, // target abort
  input wire logic [127:0] err_header_i, // header of failing packet
  // state views
  output logic [13:0] sec_status_o, // status register
  output logic status_any_o // any status bit set
);
  import aehl_pkg::*;

  logic [127:0] hdr_log_r;
  logic [13:0] stat_r;
  logic [13:0] stat_nxt;
  logic [4:0] first_ptr_r;
  logic hdr_valid_r;
  logic ack_r;
  logic [13:0] evt;
  logic [13:0] hdr_evt;
  logic [13:0] w1c;
  logic evt_any;
  logic [4:0] evt_idx;
  logic hdr_any;
  logic [31:0] rd_mux;

  // gather event pulses into status bit positions
  always_comb begin
    evt = 14'h0000;
    evt[BIT_SERR] = system_error_seen_i; // R7
    evt[BIT_PERR] = parity_error_seen_i; // R13
    evt[BIT_DISCARD] = discard_timer_expired_i; // R8
    evt[BIT_ADDR] = address_fault_i; // R9
    evt[BIT_ATTR] = attribute_fault_i; // R10
    evt[BIT_DATA] = data_fault_i; // R11
    evt[BIT_RMA] = received_master_abort_i; // R13
    evt[BIT_RTA] = received_target_abort_i; // R13
    evt = evt & STAT_LIVE_MASK; // R6 R12
  end

  assign hdr_evt = evt & STAT_HDR_MASK; // R7 R8
  assign hdr_any = |hdr_evt;

  aehl_first_bit #(
    .WIDTH(14)
  ) u_first (
    .vec_i(evt),
    .any_o(evt_any),
    .idx_o(evt_idx)
  );

  // one-cycle acknowledge; write takes effect on the ack edge
  assign waitrequest_o = (read_i | write_i) & ~ack_r;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (read_i | write_i) & ~ack_r;
    end
  end

  // write-one-to-clear only in the ack cycle, lanes honoured
  always_comb begin
    w1c = 14'h0000;
    if (write_i && ack_r && address_i == SEC_STAT_OFS) begin
      w1c[7:0] = byteenable_i[0] ? writedata_i[7:0] : 8'h00; // R15
      w1c[13:8] = byteenable_i[1] ? writedata_i[13:8] : 6'h00; // R15
    end
  end

  // set wins over clear so a racing event is never lost
  assign stat_nxt = ((stat_r & ~w1c) | evt) & STAT_LIVE_MASK; // R9 R10 R11 R13 R15

  // sticky status, untouched by reset_i
  always_ff @(posedge mclk_i) begin
    if (por_i) begin
      stat_r <= STAT_RESET; // R16
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // header log captured once per first logged error; re-armed when
  // all header-logging status bits are cleared, so a later error
  // cannot overwrite the packet software has not read yet
  always_ff @(posedge mclk_i) begin
    if (por_i) begin
      hdr_log_r <= {HL_RESET, HL_RESET, HL_RESET, HL_RESET}; // R1 R2 R3 R4 R16
      hdr_valid_r <= 1'b0;
    end else if (hdr_any && !hdr_valid_r) begin
      hdr_log_r <= err_header_i; // R5
      hdr_valid_r <= 1'b1;
    end else if ((stat_nxt & STAT_HDR_MASK) == 14'h0000) begin
      hdr_valid_r <= 1'b0;
    end
  end

  // first error pointer, held until every status bit clears
  always_ff @(posedge mclk_i) begin
    if (por_i) begin
      first_ptr_r <= PTR_RESET; // R16
    end else if (evt_any && stat_r == 14'h0000) begin
      first_ptr_r <= evt_idx; // R14
    end
  end

  // read mux; unmapped addresses return zero
  always_comb begin
    unique case (address_i)
      HL_WORD0_OFS: rd_mux = hdr_log_r[127:96]; // R1
      HL_WORD1_OFS: rd_mux = hdr_log_r[95:64]; // R2
      HL_WORD2_OFS: rd_mux = hdr_log_r[63:32]; // R3
      HL_WORD3_OFS: rd_mux = hdr_log_r[31:0]; // R4
      SEC_STAT_OFS: rd_mux = {18'h00000, stat_r}; // R6 R12 R15
      SEC_PTR_OFS: rd_mux = {27'h0000000, first_ptr_r}; // R14
      default: rd_mux = UNMAPPED_DATA;
    endcase
  end

  // read data registered, valid in the ack cycle
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      readdata_o <= 32'h00000000;
    end else if (read_i && !ack_r) begin
      readdata_o <= rd_mux;
    end
  end

  assign sec_status_o = stat_r;
  assign status_any_o = |stat_r;
endmodule : aehl_bank
`default_nettype wire

// file: aehl_bank_chk.sv
// Purpose: assertions for aehl_bank
// Assumes: sees the bank's ports only
// Notes: sticky checks muted by power-on reset only
`timescale 1ns/1ps
`default_nettype none
module aehl_bank_chk
  import aehl_pkg::*;
(
  input wire logic mclk_i, // clock
  input wire logic por_i, // power-on
  input wire logic [11:0] address_i, // addr
  input wire logic read_i, // read
  input wire logic write_i, // write
  input wire logic [31:0] writedata_i, // wdata
  input wire logic [3:0] byteenable_i, // lanes
  input wire logic [31:0] readdata_o, // rdata
  input wire logic waitrequest_o, // stall
  input wire logic system_error_seen_i, // serr
  input wire logic discard_timer_expired_i, // discard
  input wire logic data_fault_i, // data
  input wire logic [13:0] sec_status_o // status
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (por_i);
  // completing status accesses; a same-cycle event would win over the clear
  sequence s_rd; read_i && !waitrequest_o && address_i == SEC_STAT_OFS; endsequence
  sequence s_clr; write_i && !waitrequest_o && address_i == SEC_STAT_OFS && writedata_i[7] && byteenable_i[0]
    && !data_fault_i; endsequence
  a_ib_zero: assert property (!sec_status_o[13]) else $error("bit 13 set");
  a_split_zero: assert property ({sec_status_o[6:5], sec_status_o[1:0]} == 4'h0) else $error("split set");
  a_serr_set: assert property (system_error_seen_i |=> sec_status_o[12]) else $error("bit 12 missed");
  a_discard_set: assert property (discard_timer_expired_i |=> sec_status_o[10]) else $error("bit 10 missed");
  a_data_set: assert property (data_fault_i |=> sec_status_o[7]) else $error("bit 7 missed");
  a_w1c_clear: assert property (s_clr |=> !sec_status_o[7]) else $error("bit 7 kept");
  a_rsvd_read: assert property (s_rd |-> readdata_o[31:14] == 18'h0 && !readdata_o[4]) else $error("reserved");
  a_sticky_hold: assert property (sec_status_o[2] && !write_i |=> sec_status_o[2]) else $error("bit 2 lost");
endmodule : aehl_bank_chk
`default_nettype wire

// file: aehl_bank_tb.sv
// Purpose: self-checking bench for aehl_bank
// Assumes: one bus access at a time
// Notes: events are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) if ((a) !== (b)) begin mismatches++; $display("[FAIL] %0t got %h want %h", $time, a, b); end
module aehl_bank_tb;
  import aehl_pkg::*;
  localparam logic [127:0] HDR = 128'h00112233445566778899aabbccddeeff;
  logic mclk_i = 1'b0, reset_i = 1'b1, por_i = 1'b1, read_i = 1'b0, write_i = 1'b0, waitrequest_o;
  logic [11:0] address_i = 12'h000;
  logic [31:0] writedata_i = 32'h0, readdata_o, q;
  logic [3:0] byteenable_i = 4'hf;
  logic [13:0] ev = 14'h0, sec_status_o;
  logic status_any_o;
  logic [127:0] hdr = 128'h0;
  int mismatches = 0, num_checks = 0, n;
  // 10 mhz clock
  always #50 mclk_i = ~mclk_i;
  aehl_bank dut_u (.mclk_i, .reset_i, .por_i, .address_i, .read_i, .write_i, .writedata_i, .byteenable_i,
    .readdata_o, .waitrequest_o, .system_error_seen_i(ev[12]), .parity_error_seen_i(ev[11]),
    .discard_timer_expired_i(ev[10]), .address_fault_i(ev[9]), .attribute_fault_i(ev[8]), .data_fault_i(ev[7]),
    .received_master_abort_i(ev[3]), .received_target_abort_i(ev[2]), .err_header_i(hdr), .sec_status_o,
    .status_any_o);
  task results;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  // request held until waitrequest is sampled low; bounded so a hang ends the run
  task acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge mclk_i);
    read_i <= !w;
    write_i <= w;
    address_i <= a;
    writedata_i <= d;
    byteenable_i <= be;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk_i);
      if (waitrequest_o === 1'b0) break;
    end
    if (n == 20) mismatches++;
    if (n == 20) results();
    q = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask : acc
  task rd(input logic [11:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0, 4'hf);
    num_checks++;
    `CHK(q, e)
  endtask : rd
  task pulse(input logic [13:0] e, input logic [127:0] h);
    @(posedge mclk_i);
    ev <= e;
    hdr <= h;
    @(posedge mclk_i);
    ev <= 14'h0;
  endtask : pulse
  initial begin
    repeat (20) @(posedge mclk_i);
    reset_i <= 1'b0;
    por_i <= 1'b0;
    for (int i = 0; i < 5; i++) rd(HL_WORD0_OFS + 12'(4 * i), 32'h0);
    // no-log errors in one cycle: pointer takes the lower
    pulse(14'h1400, ~HDR);
    rd(SEC_STAT_OFS, 32'h00001400);
    // summary flag follows the sticky status
    num_checks++;
    `CHK(status_any_o, 1'b1)
    rd(HL_WORD3_OFS, 32'h0);
    // first logging error fills all words, writes ignored
    pulse(14'h0080, HDR);
    acc(1'b1, HL_WORD0_OFS, 32'hffffffff, 4'hf);
    for (int i = 0; i < 4; i++) rd(HL_WORD0_OFS + 12'(4 * i), HDR[127 - 32 * i -: 32]);
    for (int i = 2; i < 12; i++) if (STAT_HDR_MASK[i]) pulse(14'(1 << i), ~HDR);
    rd(SEC_STAT_OFS, 32'h00001f8c);
    rd(SEC_PTR_OFS, 32'h0000000a);
    rd(HL_WORD0_OFS, HDR[127:96]);
    // lane 1 clears only bits 13:8
    acc(1'b1, SEC_STAT_OFS, 32'hffffffff, 4'h2);
    rd(SEC_STAT_OFS, 32'h0000008c);
    acc(1'b1, SEC_STAT_OFS, 32'h00000080, 4'hf);
    rd(SEC_STAT_OFS, 32'h0000000c);
    rd(12'h200, 32'h0);
    // plain reset keeps sticky bits, power-on clears them
    reset_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    rd(SEC_STAT_OFS, 32'h0000000c);
    por_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    por_i <= 1'b0;
    rd(SEC_PTR_OFS, 32'h0);
    num_checks++;
    `CHK(status_any_o, 1'b0)
    results();
  end
endmodule : aehl_bank_tb
bind aehl_bank aehl_bank_chk chk_u (.*);
`default_nettype wire
